// *** hw/cct_pkg.sv ***
package cct_pkg;
  localparam int CCT_ADDR_W = 16;
  localparam int CCT_DATA_W = 8;
  // register offsets
  localparam logic [15:0] CCT_OFF_CLASSIC = 16'h184B;
  localparam logic [15:0] CCT_OFF_FAST = 16'h184C;
  localparam logic [15:0] CCT_OFF_MMC = 16'h184D;
  localparam logic [15:0] CCT_OFF_PAD = 16'h1880;
  // reset values
  localparam logic [7:0] CCT_RST_CLASSIC = 8'h59;
  localparam logic [7:0] CCT_RST_FAST = 8'h54;
  localparam logic [7:0] CCT_RST_MMC = 8'h95;
  localparam logic [7:0] CCT_RST_PAD = 8'h00;
  // field positions
  localparam int CCT_SYNC_LSB = 6;
  localparam int CCT_CTRL_LSB = 4;
  localparam int CCT_CAP_LSB = 0;
  localparam int CCT_CAP_W = 4;
  localparam int CCT_PAD_LSB = 0;
  localparam int CCT_PAD_W = 2;
  localparam int CCT_MAX_STAGES = 4;
  // stage-count codes
  localparam logic [1:0] CCT_CODE_2 = 2'h0;
  localparam logic [1:0] CCT_CODE_3 = 2'h1;
  localparam logic [1:0] CCT_CODE_4 = 2'h2;
  // card type select
  typedef enum logic [1:0] {
    CCT_CARD_CLASSIC = 2'h0,
    CCT_CARD_FAST = 2'h1,
    CCT_CARD_MMC = 2'h3
  } cct_card_e;

  // stage count 2..4 from a two-bit code; unused code maps to four
  function automatic logic [2:0] cct_stages(input logic [1:0] code);
    logic [2:0] n;
    n = 3'h4;
    case (code)
      CCT_CODE_2: n = 3'h2;
      CCT_CODE_3: n = 3'h3;
      CCT_CODE_4: n = 3'h4;
      default: n = 3'h4;
    endcase
    return n;
  endfunction
endpackage

// *** hw/cct_delay_line.sv ***
`timescale 1ns/1ps
module cct_delay_line
  import cct_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [2:0] stages,
  input wire logic [WIDTH-1:0] dataIn,
  output logic [WIDTH-1:0] dataOut
);
  logic [WIDTH-1:0] pipe [CCT_MAX_STAGES];
  logic [WIDTH-1:0] next_pipe [CCT_MAX_STAGES];

  always_comb begin
    next_pipe[0] = dataIn;
    for (int i = 1; i < CCT_MAX_STAGES; i++) begin
      next_pipe[i] = pipe[i-1];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < CCT_MAX_STAGES; i++) begin
        pipe[i] <= '0;
      end
    end else begin
      pipe <= next_pipe;
    end
  end

  // tap chosen by stage count; stage 1 is only read by stage 2 onward
  always_comb begin
    case (stages)
      3'h2: dataOut = pipe[1];
      3'h3: dataOut = pipe[2];
      default: dataOut = pipe[3];
    endcase
  end
endmodule

// *** hw/card_capture_timing_config.sv ***
// Functional notes
// RULE1: read sync field picks 2, 3 or 4 stages for read data and response.
// RULE2: control delay field picks 2, 3 or 4 delay stages for control logic.
// RULE3: low four bits of each timing register give capture clock delay.
// RULE4: three independent timing copies: classic SD, fast SD, MMC, own resets.
// RULE5: pad drive field selects 6, 8, 10 or 12 mA; 6 mA after reset.
// RULE6: unused code 11 in stage fields behaves as four stages.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module card_capture_timing_config
  import cct_pkg::*;
#(
  parameter int READ_W = 5
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [CCT_ADDR_W-1:0] regAddr,
  input wire logic [CCT_DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [CCT_DATA_W-1:0] regRdData,
  input wire logic [1:0] cardType,
  input wire logic [READ_W-1:0] cardReadIn,
  output logic [READ_W-1:0] cardReadSync,
  input wire logic controlIn,
  output logic controlDelayed,
  output logic [2:0] readSyncDepth,
  output logic [2:0] controlDelayStages,
  output logic [CCT_CAP_W-1:0] captureClockDelay,
  output logic [CCT_PAD_W-1:0] padDriveSelect
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] classicTiming, fastTiming, mmcTiming, cardPadDrive;
  logic [7:0] next_classicTiming, next_fastTiming, next_mmcTiming, next_cardPadDrive;
  logic [7:0] rdData, next_rdData;
  logic [7:0] activeTiming;
  logic [2:0] next_syncDepth, next_ctrlStages;
  logic [2:0] syncDepthQ, ctrlStagesQ;

  // each copy decoded separately so a write hits at most one; unmapped addresses hit none
  always_comb begin
    next_classicTiming = classicTiming;
    next_fastTiming = fastTiming;
    next_mmcTiming = mmcTiming;
    next_cardPadDrive = cardPadDrive;
    if (regWrite) begin
      if (regAddr == CCT_OFF_CLASSIC) begin
        next_classicTiming = regWrData; // RULE4
      end else if (regAddr == CCT_OFF_FAST) begin
        next_fastTiming = regWrData; // RULE4
      end else if (regAddr == CCT_OFF_MMC) begin
        next_mmcTiming = regWrData; // RULE4
      end else if (regAddr == CCT_OFF_PAD) begin
        next_cardPadDrive = {6'h00, regWrData[CCT_PAD_LSB +: CCT_PAD_W]}; // RULE5
      end
    end
  end

  // unmapped addresses read as zero
  always_comb begin
    next_rdData = 8'h00;
    if (regRead) begin
      if (regAddr == CCT_OFF_CLASSIC) begin
        next_rdData = classicTiming;
      end else if (regAddr == CCT_OFF_FAST) begin
        next_rdData = fastTiming;
      end else if (regAddr == CCT_OFF_MMC) begin
        next_rdData = mmcTiming;
      end else if (regAddr == CCT_OFF_PAD) begin
        next_rdData = cardPadDrive;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      classicTiming <= CCT_RST_CLASSIC; // RULE4
      fastTiming <= CCT_RST_FAST; // RULE4
      mmcTiming <= CCT_RST_MMC; // RULE4
      cardPadDrive <= CCT_RST_PAD; // RULE5
      rdData <= 8'h00;
    end else begin
      classicTiming <= next_classicTiming;
      fastTiming <= next_fastTiming;
      mmcTiming <= next_mmcTiming;
      cardPadDrive <= next_cardPadDrive;
      rdData <= next_rdData;
    end
  end

  assign regRdData = rdData;

  ////////////////////////////////////////////////////////////////////////
  // active copy follows the card type; unknown type falls back to classic
  always_comb begin
    case (cardType)
      CCT_CARD_FAST: activeTiming = fastTiming;
      CCT_CARD_MMC: activeTiming = mmcTiming;
      default: activeTiming = classicTiming;
    endcase
  end

  always_comb begin
    next_syncDepth = cct_stages(activeTiming[CCT_SYNC_LSB +: 2]); // RULE1 RULE6
    next_ctrlStages = cct_stages(activeTiming[CCT_CTRL_LSB +: 2]); // RULE2 RULE6
  end

  // depth is registered: a change lands one cycle after the write or type switch
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      syncDepthQ <= 3'(CCT_MAX_STAGES);
      ctrlStagesQ <= 3'(CCT_MAX_STAGES);
    end else begin
      syncDepthQ <= next_syncDepth;
      ctrlStagesQ <= next_ctrlStages;
    end
  end

  assign readSyncDepth = syncDepthQ;
  assign controlDelayStages = ctrlStagesQ;
  assign captureClockDelay = activeTiming[CCT_CAP_LSB +: CCT_CAP_W]; // RULE3
  assign padDriveSelect = cardPadDrive[CCT_PAD_LSB +: CCT_PAD_W]; // RULE5

  ////////////////////////////////////////////////////////////////////////
  // read data and response synchronizer, length set by software
  cct_delay_line #(.WIDTH(READ_W)) uReadSync (
    .clk_sys(clk_sys),
    .reset(reset),
    .stages(syncDepthQ),
    .dataIn(cardReadIn),
    .dataOut(cardReadSync)
  ); // RULE1

  cct_delay_line #(.WIDTH(1)) uCtrlDelay (
    .clk_sys(clk_sys),
    .reset(reset),
    .stages(ctrlStagesQ),
    .dataIn(controlIn),
    .dataOut(controlDelayed)
  ); // RULE2

  ////////////////////////////////////////////////////////////////////////
  property p_classic_write;
    @(posedge clk_sys) disable iff (reset)
    regWrite && regAddr == CCT_OFF_CLASSIC |=> classicTiming == $past(regWrData);
  endproperty
  a_classic_write: assert property (p_classic_write) else $error("classic write lost"); // RULE4

  property p_copies_independent;
    @(posedge clk_sys) disable iff (reset)
    regWrite && regAddr == CCT_OFF_FAST |=> $stable(mmcTiming) && $stable(classicTiming);
  endproperty
  a_copies_independent: assert property (p_copies_independent) else $error("copy disturbed"); // RULE4

  property p_pad_reserved;
    @(posedge clk_sys) disable iff (reset)
    regRead && regAddr == CCT_OFF_PAD |=> regRdData[7:2] == 6'h00;
  endproperty
  a_pad_reserved: assert property (p_pad_reserved) else $error("pad reserved bits set"); // RULE5

  property p_pad_drive;
    @(posedge clk_sys) disable iff (reset)
    regWrite && regAddr == CCT_OFF_PAD |=> padDriveSelect == $past(regWrData[1:0]);
  endproperty
  a_pad_drive: assert property (p_pad_drive) else $error("pad drive wrong"); // RULE5

  property p_sync_code;
    @(posedge clk_sys) disable iff (reset)
    activeTiming[7:6] == CCT_CODE_3 |=> readSyncDepth == 3'h3;
  endproperty
  a_sync_code: assert property (p_sync_code) else $error("sync depth wrong"); // RULE1

  property p_ctrl_code;
    @(posedge clk_sys) disable iff (reset)
    activeTiming[5:4] == CCT_CODE_2 |=> controlDelayStages == 3'h2;
  endproperty
  a_ctrl_code: assert property (p_ctrl_code) else $error("control stages wrong"); // RULE2

  property p_code11;
    @(posedge clk_sys) disable iff (reset)
    activeTiming[7:6] == 2'h3 |=> readSyncDepth == 3'h4;
  endproperty
  a_code11: assert property (p_code11) else $error("code 11 not four"); // RULE6

  sequence s_steady_two;
    readSyncDepth == 3'h2 [*3];
  endsequence
  property p_sync_latency;
    @(posedge clk_sys) disable iff (reset)
    s_steady_two |-> cardReadSync == $past(cardReadIn, 2);
  endproperty
  a_sync_latency: assert property (p_sync_latency) else $error("sync latency wrong"); // RULE1

  property p_capture;
    @(posedge clk_sys) disable iff (reset)
    cardType == CCT_CARD_MMC |-> captureClockDelay == mmcTiming[3:0];
  endproperty
  a_capture: assert property (p_capture) else $error("capture delay wrong"); // RULE3

  property p_fast_write;
    @(posedge clk_sys) disable iff (reset)
    regWrite && regAddr == CCT_OFF_FAST |=> fastTiming == $past(regWrData);
  endproperty
  a_fast_write: assert property (p_fast_write) else $error("fast write lost"); // RULE4

  property p_mmc_write;
    @(posedge clk_sys) disable iff (reset)
    regWrite && regAddr == CCT_OFF_MMC |=> mmcTiming == $past(regWrData);
  endproperty
  a_mmc_write: assert property (p_mmc_write) else $error("mmc write lost"); // RULE4

  // read data drops back to zero so a stale value is never taken for a fresh one
  property p_read_idle;
    @(posedge clk_sys) disable iff (reset)
    !regRead |=> regRdData == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data not cleared"); // RULE4

  property p_read_fast;
    @(posedge clk_sys) disable iff (reset)
    regRead && regAddr == CCT_OFF_FAST |=> regRdData == $past(fastTiming);
  endproperty
  a_read_fast: assert property (p_read_fast) else $error("fast read wrong"); // RULE4

  // five edges out of reset, so the chain holds nothing from before the reset
  sequence s_steady_four;
    controlDelayStages == 3'h4 [*5];
  endsequence
  property p_ctrl_latency;
    @(posedge clk_sys) disable iff (reset)
    s_steady_four |-> controlDelayed == $past(controlIn, 4);
  endproperty
  a_ctrl_latency: assert property (p_ctrl_latency) else $error("control latency wrong"); // RULE2
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import cct_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdData;
  logic [1:0] cardType = 2'h0;
  logic [4:0] cardReadIn = 5'h00;
  logic [4:0] cardReadSync;
  logic controlIn = 1'b0;
  logic controlDelayed;
  logic [2:0] readSyncDepth;
  logic [2:0] controlDelayStages;
  logic [3:0] captureClockDelay;
  logic [1:0] padDriveSelect;
  int errors = 0;
  int n_compared = 0;
  logic [31:0] seed = 32'h54001141;
  logic [7:0] shadow [4];
  localparam logic [15:0] OFFS [4] = '{CCT_OFF_CLASSIC, CCT_OFF_FAST, CCT_OFF_MMC, CCT_OFF_PAD};
  always #12.5 clk_sys = ~clk_sys;
  card_capture_timing_config #(.READ_W(5)) dut (.clk_sys(clk_sys), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .cardType(cardType), .cardReadIn(cardReadIn),
    .cardReadSync(cardReadSync), .controlIn(controlIn), .controlDelayed(controlDelayed),
    .readSyncDepth(readSyncDepth), .controlDelayStages(controlDelayStages),
    .captureClockDelay(captureClockDelay), .padDriveSelect(padDriveSelect));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // reserved code 11 must still give four stages, never fewer
  function automatic logic [7:0] expStages(input logic [1:0] code);
    return (code == 2'h0) ? 8'h02 : (code == 2'h1) ? 8'h03 : 8'h04;
  endfunction
  function automatic int copyIdx(input logic [1:0] ct);
    return (ct == 2'h3) ? 2 : (ct == 2'h1) ? 1 : 0;
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 chk("regRdData", regRdData, exp);
  endtask
  task automatic outs();
    logic [7:0] t;
    t = shadow[copyIdx(cardType)];
    chk("readSyncDepth", 8'(readSyncDepth), expStages(t[7:6]));
    chk("controlDelayStages", 8'(controlDelayStages), expStages(t[5:4]));
    chk("captureClockDelay", 8'(captureClockDelay), 8'(t[3:0]));
    chk("padDriveSelect", 8'(padDriveSelect), 8'(shadow[3][1:0]));
  endtask
  // both chains start flat, so the first edge showing the new value is the depth
  task automatic delays();
    logic [4:0] v;
    logic c;
    int ns;
    int nc;
    logic [7:0] t;
    v = cardReadIn ^ (5'(rnd()) | 5'h01);
    c = ~controlIn;
    ns = 0;
    nc = 0;
    t = shadow[copyIdx(cardType)];
    @(posedge clk_sys);
    cardReadIn <= v;
    controlIn <= c;
    for (int k = 1; k < 8; k++) begin
      @(posedge clk_sys);
      #1;
      if (ns == 0 && cardReadSync === v) ns = k;
      if (nc == 0 && controlDelayed === c) nc = k;
    end
    chk("readDelay", 8'(ns), expStages(t[7:6]));
    chk("ctrlDelay", 8'(nc), expStages(t[5:4]));
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [1:0] ct;
    int j;
    shadow = '{CCT_RST_CLASSIC, CCT_RST_FAST, CCT_RST_MMC, CCT_RST_PAD};
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    for (int k = 0; k < 4; k++) rd(OFFS[k], shadow[k]);
    outs();
    $display("test reset values done");
    // every card type meets every code of both stage fields
    for (int k = 0; k < 16; k++) begin
      ct = 2'(k >> 2);
      d = {2'(k), 2'(~k), 4'(rnd())};
      @(posedge clk_sys);
      cardType <= ct;
      wr(OFFS[copyIdx(ct)], d);
      shadow[copyIdx(ct)] = d;
      j = (copyIdx(ct) + 1) % 3;
      d = 8'(rnd());
      wr(OFFS[j], d);
      shadow[j] = d;
      d = 8'(rnd());
      wr(CCT_OFF_PAD, d);
      shadow[3] = d & 8'h03;
      repeat (3) @(posedge clk_sys);
      #1;
      outs();
      delays();
      for (int m = 0; m < 4; m++) rd(OFFS[m], shadow[m]);
    end
    $display("test copies and stages done");
    wr(16'h184E, 8'hFF);
    wr(16'h1881, 8'hFF);
    rd(16'h184E, 8'h00);
    rd(16'h1881, 8'h00);
    rd(CCT_OFF_MMC, shadow[2]);
    @(posedge clk_sys);
    #1 chk("rdDataIdle", regRdData, 8'h00);
    for (int m = 0; m < 4; m++) rd(OFFS[m], shadow[m]);
    $display("test unmapped access done");
    // reset in mid-run must restore every copy and the pad default over written values
    @(posedge clk_sys);
    reset <= 1'b1;
    controlIn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    shadow = '{CCT_RST_CLASSIC, CCT_RST_FAST, CCT_RST_MMC, CCT_RST_PAD};
    for (int m = 0; m < 4; m++) rd(OFFS[m], shadow[m]);
    outs();
    delays();
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
